/* hw/pairing_cfg.svh */
// Purpose: Constants for the transponder pairing controller
// Assumes: 25 MHz system clock
// Notes:   Times are kept in their own unit; cycle counts derive from them
`ifndef PAIRING_CFG_SVH
`define PAIRING_CFG_SVH

// ==========================================================
// Clock and timing
`define CLK_HZ             25000000
`define PAIR_WINDOW_MS     10000
// Window length in cycles, a longest time, so it rounds down
`define PAIR_WINDOW_CYCLES ((`PAIR_WINDOW_MS) * ((`CLK_HZ) / 1000))

// ==========================================================
// Code store and pairing budget
`define CODE_W             32
`define PAIR_MAX           2'h2
`define CODE_RST           32'h0000_0000
`define COUNT_RST          2'h0

`endif

/* hw/pairing_pkg.sv */
// Purpose: Types shared by the pairing controller files
// Assumes: Nothing beyond the cfg header
// Notes:   Constants live in pairing_cfg.svh
package pairing_pkg;

  // ==========================================================
  // Controller states
  typedef enum logic [1:0] {
    ST_INIT = 2'h0,
    ST_OPEN = 2'h1,
    ST_LOCK = 2'h2,
    ST_RUN  = 2'h3
  } state_t;

endpackage

/* hw/pair_timer.sv */
// Purpose: One-shot down counter that times the pairing window
// Assumes: start is a one-cycle pulse from the same clock
// Notes:   Loads CYCLES-2 so the window it closes stands CYCLES cycles;
//          CYCLES must be 2 or more
`timescale 1ns/1ps
module pair_timer #(
  parameter int unsigned CYCLES = 250000000,
  parameter int unsigned W      = $clog2(CYCLES + 1)
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic start,
  output logic      expired
);

  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;
  logic         run_q;
  logic         run_d;
  logic         exp_q;
  logic         exp_d;

  // ==========================================================
  // Next count; a fresh start always reloads the full window
  always_comb begin
    cnt_d = cnt_q;
    run_d = run_q;
    exp_d = 1'b0;
    if (start) begin
      // Two cycles go to the expiry flop and the state change after it
      cnt_d = W'(CYCLES - 2);
      run_d = 1'b1;
    end else if (run_q) begin
      if (cnt_q == '0) begin
        run_d = 1'b0;
        exp_d = 1'b1;
      end else begin
        cnt_d = cnt_q - W'(1);
      end
    end
  end

  // Registers only
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q <= '0;
      run_q <= 1'b0;
      exp_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      run_q <= run_d;
      exp_q <= exp_d;
    end
  end

  assign expired = exp_q;

endmodule

/* hw/transponder_pairing_control.sv */
// Purpose: Decides whether, when and how a blank transponder is paired
// Assumes: rst is the power cycle; stored code and count come from NVM
// Notes:   NVM is outside; this block loads it at init and writes it back
`timescale 1ns/1ps
`include "pairing_cfg.svh"
module transponder_pairing_control #(
  parameter int unsigned CODE_W        = `CODE_W,
  parameter int unsigned WINDOW_CYCLES = `PAIR_WINDOW_CYCLES
) (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              init_done,
  input  wire logic              repair_variant,
  input  wire logic              tag_present,
  input  wire logic              tag_blank,
  input  wire logic              tag_id_ok,
  input  wire logic [CODE_W-1:0] tag_code,
  input  wire logic [CODE_W-1:0] nv_code_in,
  input  wire logic [1:0]        nv_count_in,
  output logic                   cfg_open,
  output logic                   run_ok,
  output logic                   guard_closed,
  output logic                   pair_done,
  output logic                   reject,
  output logic                   nv_write,
  output logic                   tag_prog,
  output logic [CODE_W-1:0]      stored_code,
  output logic [1:0]             pair_count
);

  pairing_pkg::state_t state_q;
  pairing_pkg::state_t state_d;
  logic [CODE_W-1:0]   code_q;
  logic [CODE_W-1:0]   code_d;
  logic [1:0]          count_q;
  logic [1:0]          count_d;
  logic                variant_q;
  logic                variant_d;
  logic                sync1_q;
  logic                sync2_q;
  logic                sync3_q;
  logic                pres_q;
  logic                pres_d;
  logic                attempt;
  logic                qualifies;
  logic                win_start;
  logic                win_exp;
  logic                open_q;
  logic                open_d;
  logic                run_q;
  logic                run_d;
  logic                guard_q;
  logic                guard_d;
  logic                done_q;
  logic                done_d;
  logic                rej_q;
  logic                rej_d;
  logic                wr_q;
  logic                wr_d;
  logic                prog_q;
  logic                prog_d;

  // ==========================================================
  // Presence pin: three stages, change accepted once stages 2 and 3 agree
  always_comb begin
    pres_d = pres_q;
    if (sync2_q == sync3_q) begin
      pres_d = sync2_q;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      sync3_q <= 1'b0;
      pres_q  <= 1'b0;
    end else begin
      sync1_q <= tag_present;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      pres_q  <= pres_d;
    end
  end

  // One attempt per arrival; a tag left in range is not retried
  assign attempt = pres_d & ~pres_q;

  // Qualification covers every refusal case
  assign qualifies = tag_blank & tag_id_ok & variant_q
                   & (count_q < `PAIR_MAX);

  // ==========================================================
  // Window timer, started once as init ends
  assign win_start = (state_q == pairing_pkg::ST_INIT) & init_done;

  pair_timer #(
    .CYCLES (WINDOW_CYCLES)
  ) u_timer (
    .clk     (clk),
    .rst     (rst),
    .start   (win_start),
    .expired (win_exp)
  );

  // ==========================================================
  // Main sequence; expiry wins over an attempt in the same cycle
  always_comb begin
    state_d   = state_q;
    code_d    = code_q;
    count_d   = count_q;
    variant_d = variant_q;
    rej_d     = 1'b0;
    wr_d      = 1'b0;
    prog_d    = 1'b0;
    case (state_q)
      pairing_pkg::ST_INIT: begin
        // Strap and NVM contents are caught only once, at end of init
        if (init_done) begin
          code_d    = nv_code_in;
          count_d   = nv_count_in;
          variant_d = repair_variant;
          state_d   = pairing_pkg::ST_OPEN;
        end
      end
      pairing_pkg::ST_OPEN: begin
        if (win_exp) begin
          state_d = pairing_pkg::ST_RUN;
        end else if (attempt && qualifies) begin
          code_d  = tag_code;
          count_d = 2'(count_q + 2'h1);
          wr_d    = 1'b1;
          prog_d  = 1'b1;
          state_d = pairing_pkg::ST_LOCK;
        end else if (attempt) begin
          rej_d   = 1'b1;
        end
      end
      pairing_pkg::ST_LOCK: begin
        // Only a power cycle leaves this state
        state_d = pairing_pkg::ST_LOCK;
      end
      pairing_pkg::ST_RUN: begin
        state_d = pairing_pkg::ST_RUN;
      end
      default: begin
        state_d = pairing_pkg::ST_INIT;
      end
    endcase
  end

  // Status outputs follow the next state so they line up with it
  always_comb begin
    open_d  = (state_d == pairing_pkg::ST_OPEN);
    run_d   = (state_d == pairing_pkg::ST_RUN);
    done_d  = (state_d == pairing_pkg::ST_LOCK);
    // Only the current code closes the guard, so an old tag never does
    guard_d = run_d & pres_d & (tag_code == code_d);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q   <= pairing_pkg::ST_INIT;
      code_q    <= `CODE_RST;
      count_q   <= `COUNT_RST;
      variant_q <= 1'b0;
      open_q    <= 1'b0;
      run_q     <= 1'b0;
      guard_q   <= 1'b0;
      done_q    <= 1'b0;
      rej_q     <= 1'b0;
      wr_q      <= 1'b0;
      prog_q    <= 1'b0;
    end else begin
      state_q   <= state_d;
      code_q    <= code_d;
      count_q   <= count_d;
      variant_q <= variant_d;
      open_q    <= open_d;
      run_q     <= run_d;
      guard_q   <= guard_d;
      done_q    <= done_d;
      rej_q     <= rej_d;
      wr_q      <= wr_d;
      prog_q    <= prog_d;
    end
  end

  assign cfg_open     = open_q;
  assign run_ok       = run_q;
  assign guard_closed = guard_q;
  assign pair_done    = done_q;
  assign reject       = rej_q;
  assign nv_write     = wr_q;
  assign tag_prog     = prog_q;
  assign stored_code  = code_q;
  assign pair_count   = count_q;

  // ==========================================================
  // Assertions
  sequence s_try_open;
    (state_q == pairing_pkg::ST_OPEN) && !win_exp && attempt;
  endsequence

  sequence s_paired;
    nv_write && tag_prog && pair_done && !cfg_open;
  endsequence

  property p_only_in_window;
    @(posedge clk) disable iff (rst)
      nv_write |-> $past(state_q) == pairing_pkg::ST_OPEN;
  endproperty
  a_only_in_window: assert property (p_only_in_window)
    else $error("Pairing write outside the window");

  property p_count_step;
    @(posedge clk) disable iff (rst)
      nv_write |-> ($past(count_q) < 2'h2)
               && (pair_count == 2'($past(count_q) + 2'h1));
  endproperty
  a_count_step: assert property (p_count_step)
    else $error("Pairing count wrong after write");

  property p_reject;
    @(posedge clk) disable iff (rst)
      (s_try_open and !qualifies) |=> reject && !nv_write && cfg_open;
  endproperty
  a_reject: assert property (p_reject)
    else $error("Unqualified transponder not rejected");

  property p_code_replaced;
    @(posedge clk) disable iff (rst)
      nv_write |-> stored_code == $past(tag_code);
  endproperty
  a_code_replaced: assert property (p_code_replaced)
    else $error("Stored code not replaced on pairing");

  property p_auto_pair;
    @(posedge clk) disable iff (rst)
      (s_try_open and qualifies) |=> s_paired;
  endproperty
  a_auto_pair: assert property (p_auto_pair)
    else $error("Qualifying transponder not paired");

  property p_lock_held;
    @(posedge clk) disable iff (rst)
      pair_done |=> (pair_done && !run_ok && !guard_closed)[*8];
  endproperty
  a_lock_held: assert property (p_lock_held)
    else $error("Normal run resumed without power cycle");

  property p_unique_never;
    @(posedge clk) disable iff (rst)
      (state_q != pairing_pkg::ST_INIT) && !variant_q |-> !wr_d;
  endproperty
  a_unique_never: assert property (p_unique_never)
    else $error("Unique variant accepted a pairing");

  property p_prog_once;
    @(posedge clk) disable iff (rst)
      tag_prog |-> $past(tag_blank) ##1 (!tag_prog)[*8];
  endproperty
  a_prog_once: assert property (p_prog_once)
    else $error("Transponder programmed twice or not blank");

  property p_expire;
    @(posedge clk) disable iff (rst)
      (state_q == pairing_pkg::ST_OPEN) && win_exp
        |=> run_ok && !cfg_open && $stable(pair_count)
            && $stable(stored_code) && !nv_write;
  endproperty
  a_expire: assert property (p_expire)
    else $error("Window expiry did not resume normal run");

endmodule

/* tb/tag_model.sv */
// Purpose: Behavioural transponder seen by the pairing reader
// Assumes: Bench loads a new tag only while the tag is away
// Notes:   Away tag shows inverted code lines, never a stale value
`timescale 1ns/1ps
module tag_model (
  input  wire logic        clk,
  input  wire logic        load,
  input  wire logic        place,
  input  wire logic        blank_in,
  input  wire logic        id_in,
  input  wire logic [31:0] code_in,
  input  wire logic        tag_prog,
  output logic             tag_present,
  output logic             tag_blank,
  output logic             tag_id_ok,
  output logic [31:0]      tag_code
);
  // ==========================================================
  // Tag memory
  logic        blank_q;
  logic        id_q;
  logic [31:0] code_q;
  // One-time programmable, so a second program finds it not blank
  always @(posedge clk) begin
    if (load) begin
      blank_q <= blank_in;
      id_q    <= id_in;
      code_q  <= code_in;
    end else if (tag_prog && place) begin
      blank_q <= 1'b0;
    end
  end
  // Lines only carry tag data while the tag is in range
  assign tag_present = place;
  assign tag_blank   = place & blank_q;
  assign tag_id_ok   = place & id_q;
  assign tag_code    = place ? code_q : ~code_q;
endmodule

/* tb/transponder_pairing_control_tb.sv */
// Purpose: Self-checking bench for the pairing controller
// Assumes: Short window parameter, 25 MHz clock
// Notes:   Outcomes are sampled 1 ns after each rising edge
`timescale 1ns/1ps
module transponder_pairing_control_tb;
  // ==========================================================
  // Signals
  localparam int WIN = 50;
  logic        clk, rst, init_done, repair_variant, load, place;
  logic        blank_in, id_in, tag_present, tag_blank, tag_id_ok;
  logic        cfg_open, run_ok, guard_closed, pair_done, reject;
  logic        nv_write, tag_prog;
  logic [31:0] code_in, tag_code, nv_code_in, stored_code, a, b, c;
  logic [1:0]  nv_count_in, pair_count, npair;
  int          mismatches, cmp_count, cycles, k;

  transponder_pairing_control #(.CODE_W(32), .WINDOW_CYCLES(WIN)) dut (
    .clk, .rst, .init_done, .repair_variant, .tag_present, .tag_blank,
    .tag_id_ok, .tag_code, .nv_code_in, .nv_count_in, .cfg_open,
    .run_ok, .guard_closed, .pair_done, .reject, .nv_write, .tag_prog,
    .stored_code, .pair_count);
  tag_model tag (.clk, .load, .place, .blank_in, .id_in, .code_in,
    .tag_prog, .tag_present, .tag_blank, .tag_id_ok, .tag_code);

  // Clock, and a cycle ceiling so a hang still reaches the report
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 4000) begin
      mismatches++;
      finish_test();
    end
  end

  // Counted comparison with an immediate report
  task automatic check(input bit ok, input string msg);
    cmp_count++;
    if (!ok) begin
      mismatches++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask
  task automatic finish_test();
    $display("mismatches %0d of %0d compares", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // Power cycle with a given strap and stored contents
  task automatic power_up(input logic v, input logic [31:0] cd,
                          input logic [1:0] n);
    @(posedge clk);
    rst <= 1'b1;
    repair_variant <= v;
    nv_code_in <= cd;
    nv_count_in <= n;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    init_done <= 1'b1;
    @(posedge clk);
    init_done <= 1'b0;
    @(posedge clk);
    #1;
    check(cfg_open === 1'b1 && stored_code === cd &&
          pair_count === n, "init load");
  endtask
  // Swap in a different tag while nothing is in range
  task automatic new_tag(input logic bl, input logic id,
                         input logic [31:0] cd);
    @(posedge clk);
    load <= 1'b1;
    blank_in <= bl;
    id_in <= id;
    code_in <= cd;
    @(posedge clk);
    load <= 1'b0;
  endtask
  // Bring the tag into range, watch 8 cycles, then take it away
  task automatic attempt(input bit ep, input bit er);
    bit sp;
    bit sr;
    sp = 0;
    sr = 0;
    @(posedge clk);
    place <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      #1;
      sp |= (nv_write === 1'b1 && tag_prog === 1'b1);
      sr |= (reject === 1'b1);
    end
    check(sp == ep && sr == er && pair_done === ep, "attempt result");
    @(posedge clk);
    place <= 1'b0;
    repeat (5) @(posedge clk);
    #1;
  endtask
  // Let the window run out within a bounded wait
  task automatic wait_run();
    k = 0;
    while (run_ok !== 1'b1 && k < 80) begin
      @(posedge clk);
      #1;
      k++;
    end
  endtask

  // Expected outcome of one arrival in the window, from the refusal list
  function automatic bit pair_ok(input bit bl, input bit id, input bit v,
                                 input logic [1:0] cnt);
    return bl && id && v && (cnt < 2'h2);
  endfunction

  // Main sequence
  initial begin
    {rst, init_done, repair_variant, load, place} = 5'h10;
    {blank_in, id_in, code_in, nv_code_in, nv_count_in} = '0;
    {mismatches, cmp_count, cycles} = '0;
    void'($urandom(10));
    a = $urandom;
    b = $urandom;
    c = $urandom;
    power_up(1'b1, a, 2'h0);
    new_tag(1'b1, 1'b1, b);
    attempt(pair_ok(1'b1, 1'b1, 1'b1, 2'h0), 1'b0);
    check(stored_code === b && pair_count === 2'h1, "store");
    wait_run();
    check(run_ok === 1'b0 && cfg_open === 1'b0, "held");
    power_up(1'b1, b, 2'h1);
    attempt(pair_ok(1'b0, 1'b1, 1'b1, 2'h1), 1'b1);
    new_tag(1'b1, 1'b0, c);
    attempt(pair_ok(1'b1, 1'b0, 1'b1, 2'h1), 1'b1);
    check(cfg_open === 1'b1, "open after reject");
    wait_run();
    check(run_ok === 1'b1 && stored_code === b &&
          pair_count === 2'h1, "expiry");
    new_tag(1'b0, 1'b1, b);
    attempt(0, 0);
    check(guard_closed === 1'b0, "guard after leave");
    @(posedge clk);
    place <= 1'b1;
    repeat (8) @(posedge clk);
    #1;
    check(guard_closed === 1'b1, "new tag guards");
    // The bench swaps tags only while nothing is in range
    @(posedge clk);
    place <= 1'b0;
    repeat (5) @(posedge clk);
    new_tag(1'b0, 1'b1, a);
    @(posedge clk);
    place <= 1'b1;
    repeat (8) @(posedge clk);
    #1;
    check(guard_closed === 1'b0, "old tag refused");
    @(posedge clk);
    place <= 1'b0;
    repeat (5) @(posedge clk);
    npair = 2'h2 + 2'($urandom % 2);
    power_up(1'b1, c, npair);
    new_tag(1'b1, 1'b1, a);
    attempt(pair_ok(1'b1, 1'b1, 1'b1, npair), 1'b1);
    power_up(1'b0, c, 2'h0);
    attempt(pair_ok(1'b1, 1'b1, 1'b0, 2'h0), 1'b1);
    power_up(1'b1, c, 2'h0);
    wait_run();
    // Polling starts one edge into a window of WIN cycles
    check(k == WIN - 1, "window length");
    attempt(0, 0);
    check(stored_code === c && pair_count === 2'h0, "late");
    finish_test();
  end
endmodule
